// file: common/osc_trim_pkg.sv
// Purpose: shared constants for the reference oscillator trim register bank
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: register offsets are byte addresses
package osc_trim_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_TRIM_HIGH = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_TRIM_LOW = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_GUARD = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CLKSEL = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] GUARD_UNLOCK_KEY = 8'h26;
	localparam logic GUARD_RESET = 1'b0;
	localparam logic CLKSEL_RESET = 1'b0;
	localparam int TC_MSB = 15;
	localparam int TC_LSB = 12;
	localparam int FREQ_MSB = 9;
	localparam int FREQ_LSB = 0;
	localparam int COARSE_MSB = 9;
	localparam int COARSE_LSB = 6;
	localparam int FINE_MSB = 5;
	localparam int FINE_LSB = 0;
	localparam logic [15:0] TRIM_IMPL_MASK = 16'hf3ff;
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_QUAL_BIT = 1;
	localparam int STAT_LOADED_BIT = 2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0] HSIZE_WORD = 3'b010;
endpackage

// file: design/trim_store.sv
// Purpose: holds the 16-bit combined trim word
// Assumes: caller gates writes; unimplemented bits are masked here with TRIM_IMPL_MASK
// Notes: read data come from the register itself
`timescale 1ns/1ps
module trim_store (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// write side
	input wire logic load_en,
	input wire logic [15:0] load_val,
	input wire logic wr_hi,
	input wire logic wr_lo,
	input wire logic [7:0] wr_data,
	// contents
	output logic [15:0] trim_q
);
	import osc_trim_pkg::*;
	always_ff @(posedge clk) begin
		if (rst) begin
			trim_q <= 16'h0000;
		end else if (load_en) begin
			trim_q <= load_val & TRIM_IMPL_MASK;
		end else begin
			if (wr_hi)
				trim_q[15:8] <= wr_data & TRIM_IMPL_MASK[15:8];
			if (wr_lo)
				trim_q[7:0] <= wr_data;
		end
	end
endmodule

// file: design/tc_decode.sv
// Purpose: decodes the temperature-coefficient trim code
// Assumes: driven from a register on the same clock
// Notes: outputs are registered
`timescale 1ns/1ps
module tc_decode (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// code in
	input wire logic [3:0] tc_code,
	// decoded controls
	output logic tc_enable,
	output logic tc_positive,
	output logic [2:0] tc_magnitude
);
	always_ff @(posedge clk) begin
		if (rst) begin
			tc_enable <= 1'b0;
			tc_positive <= 1'b0;
			tc_magnitude <= 3'h0;
		end else begin
			tc_enable <= (tc_code[2:0] != 3'h0);
			tc_positive <= tc_code[3];
			tc_magnitude <= tc_code[2:0];
		end
	end
endmodule

// file: design/osc_trim_regs.sv
// Purpose: trim register bank for the internal 1 MHz reference oscillator
// Assumes: AHB-Lite slave, single word transfers, one clock, synchronous reset
// Notes: factory trim value arrives on FACTORY_TRIM with FACTORY_VALID
//
// Summary of operation
// - after reset release the factory flash trim value loads into both trim registers
// - trim registers always readable; writes take effect only while guard bit is 0
// - guard bit clears only on reset or on writing 0x26 to guard register; others set it
// - accepted trim write while PLL selected clears lock and qualified flags
// - temperature coefficient trim sits in bits 15 to 12, drives compensation
// - frequency trim sits in bits 9 to 0, drives the reference oscillator
// - frequency bits 9 to 6 are the coarse control, about six percent a step
// - frequency bits 5 to 0 are the fine control, about 0.3 percent a step
// - temperature codes 0000 and 1000 switch compensation off
// - top temperature bit picks direction, lower three bits pick magnitude
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module osc_trim_regs (
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [osc_trim_pkg::ADDR_W-1:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic HREADY,
	input wire logic [31:0] HWDATA,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// factory value from flash
	input wire logic [15:0] FACTORY_TRIM,
	input wire logic FACTORY_VALID,
	// status from the pll and oscillator monitors
	input wire logic PLL_LOCK_SET,
	input wire logic OSC_QUAL_SET,
	// oscillator controls
	output logic [3:0] TEMP_COEFF_TRIM,
	output logic [9:0] REF_FREQ_TRIM,
	output logic [3:0] FREQ_COARSE,
	output logic [5:0] FREQ_FINE,
	output logic TC_COMP_ENABLE,
	output logic TC_COMP_POSITIVE,
	output logic [2:0] TC_COMP_MAGNITUDE,
	output logic PLL_LOCK_FLAG,
	output logic OSC_QUALIFIED_FLAG
);
	import osc_trim_pkg::*;

	typedef struct packed {
		logic wr_pend;
		logic [ADDR_W-1:0] addr;
		logic rd_pend;
		logic [31:0] rdata;
		logic guard;
		logic pll_sel;
		logic lock_flag;
		logic qual_flag;
		logic loaded;
		logic load_pulse;
		logic [15:0] load_val;
		logic [3:0] tc_out;
		logic [9:0] freq_out;
		logic ready;
		logic resp;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic [15:0] trim_q;
	logic wr_hi;
	logic wr_lo;
	logic trim_wr;
	logic [7:0] wdata8;

	// synchronisers for the flash-side handshake and status inputs
	logic [2:0] fv_sync_q;
	logic [2:0] lock_sync_q;
	logic [2:0] qual_sync_q;
	logic [15:0] ftrim_q;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			fv_sync_q <= 3'h0;
			lock_sync_q <= 3'h0;
			qual_sync_q <= 3'h0;
			ftrim_q <= 16'h0000;
		end else begin
			fv_sync_q <= {fv_sync_q[1:0], FACTORY_VALID};
			lock_sync_q <= {lock_sync_q[1:0], PLL_LOCK_SET};
			qual_sync_q <= {qual_sync_q[1:0], OSC_QUAL_SET};
			ftrim_q <= FACTORY_TRIM;
		end
	end

	// a level counts once stages two and three agree
	function automatic logic agreed(input logic [2:0] s);
		agreed = s[1] & s[2];
	endfunction

	function automatic logic [31:0] widen8(input logic [7:0] v);
		widen8 = {24'h000000, v};
	endfunction

	wire fv_ok = agreed(fv_sync_q);
	wire lock_ok = agreed(lock_sync_q);
	wire qual_ok = agreed(qual_sync_q);

	wire addr_phase = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ);

	always_comb begin
		s_d = s_q;
		s_d.load_pulse = 1'b0;
		s_d.ready = 1'b1;
		s_d.resp = 1'b0;
		s_d.wr_pend = addr_phase & HWRITE;
		s_d.rd_pend = addr_phase & ~HWRITE;
		if (addr_phase)
			s_d.addr = HADDR;
		wdata8 = HWDATA[7:0];
		wr_hi = 1'b0;
		wr_lo = 1'b0;
		// flash value is accepted once, only after the flash says it is valid
		if (!s_q.loaded && fv_ok) begin
			s_d.loaded = 1'b1;
			s_d.load_pulse = 1'b1;
			s_d.load_val = ftrim_q;
		end
		if (s_q.wr_pend) begin
			unique case (s_q.addr)
				OFF_TRIM_HIGH: wr_hi = ~s_q.guard;
				OFF_TRIM_LOW: wr_lo = ~s_q.guard;
				OFF_GUARD: s_d.guard = (wdata8 != GUARD_UNLOCK_KEY);
				OFF_CLKSEL: s_d.pll_sel = wdata8[0];
				default: ;
			endcase
		end
		// clearing by a trim write loses to a simultaneous set from the monitors
		if ((wr_hi | wr_lo) && s_q.pll_sel) begin
			s_d.lock_flag = 1'b0;
			s_d.qual_flag = 1'b0;
		end
		if (lock_ok)
			s_d.lock_flag = 1'b1;
		if (qual_ok)
			s_d.qual_flag = 1'b1;
		s_d.rdata = 32'h00000000;
		if (addr_phase && !HWRITE) begin
			unique case (HADDR)
				OFF_TRIM_HIGH: s_d.rdata = widen8(trim_q[15:8]);
				OFF_TRIM_LOW: s_d.rdata = widen8(trim_q[7:0]);
				OFF_GUARD: s_d.rdata = {31'h00000000, s_q.guard};
				OFF_CLKSEL: s_d.rdata = {31'h00000000, s_q.pll_sel};
				OFF_STATUS: s_d.rdata = {29'h00000000, s_q.loaded, s_q.qual_flag, s_q.lock_flag};
				default: s_d.rdata = 32'h00000000;
			endcase
		end
		s_d.tc_out = trim_q[TC_MSB:TC_LSB];
		s_d.freq_out = trim_q[FREQ_MSB:FREQ_LSB];
	end

	assign trim_wr = wr_hi | wr_lo;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			s_q <= '0;
			s_q.guard <= GUARD_RESET;
			s_q.pll_sel <= CLKSEL_RESET;
			s_q.ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	trim_store u_store (
		.clk(CLK),
		.rst(SYS_RST),
		.load_en(s_q.load_pulse),
		.load_val(s_q.load_val),
		.wr_hi(wr_hi),
		.wr_lo(wr_lo),
		.wr_data(wdata8),
		.trim_q(trim_q)
	);

	tc_decode u_tc (
		.clk(CLK),
		.rst(SYS_RST),
		.tc_code(s_q.tc_out),
		.tc_enable(TC_COMP_ENABLE),
		.tc_positive(TC_COMP_POSITIVE),
		.tc_magnitude(TC_COMP_MAGNITUDE)
	);

	// zero-wait slave: every transfer completes in its data phase
	assign HREADYOUT = s_q.ready;
	assign HRESP = s_q.resp;
	assign HRDATA = s_q.rdata;
	assign TEMP_COEFF_TRIM = s_q.tc_out;
	assign REF_FREQ_TRIM = s_q.freq_out;
	assign FREQ_COARSE = s_q.freq_out[COARSE_MSB:COARSE_LSB];
	assign FREQ_FINE = s_q.freq_out[FINE_MSB:FINE_LSB];
	assign PLL_LOCK_FLAG = s_q.lock_flag;
	assign OSC_QUALIFIED_FLAG = s_q.qual_flag;

	property p_guard_blocks;
		@(posedge CLK) disable iff (SYS_RST)
		(s_q.guard && !s_q.load_pulse) |=> $stable(trim_q);
	endproperty
	a_guard_blocks: assert property (p_guard_blocks) else $error("trim changed while guarded");

	property p_key_unlocks;
		@(posedge CLK) disable iff (SYS_RST)
		(s_q.wr_pend && s_q.addr == OFF_GUARD && HWDATA[7:0] == GUARD_UNLOCK_KEY) |=> !s_q.guard;
	endproperty
	a_key_unlocks: assert property (p_key_unlocks) else $error("key did not clear guard");

	property p_other_locks;
		@(posedge CLK) disable iff (SYS_RST)
		(s_q.wr_pend && s_q.addr == OFF_GUARD && HWDATA[7:0] != GUARD_UNLOCK_KEY) |=> s_q.guard;
	endproperty
	a_other_locks: assert property (p_other_locks) else $error("other write did not set guard");

	property p_pll_clear;
		@(posedge CLK) disable iff (SYS_RST)
		(trim_wr && s_q.pll_sel && !lock_ok && !qual_ok) |=> (!s_q.lock_flag && !s_q.qual_flag);
	endproperty
	a_pll_clear: assert property (p_pll_clear) else $error("flags not cleared by trim write");

	property p_load_once;
		@(posedge CLK) disable iff (SYS_RST)
		s_q.load_pulse |=> (trim_q == (s_q.load_val & TRIM_IMPL_MASK)) ##1 !s_q.load_pulse;
	endproperty
	a_load_once: assert property (p_load_once) else $error("factory load wrong");

	property p_unimpl_zero;
		@(posedge CLK) disable iff (SYS_RST)
		trim_q[11:10] == 2'b00;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits set");

	property p_tc_route;
		@(posedge CLK) disable iff (SYS_RST)
		##2 TEMP_COEFF_TRIM == $past(trim_q[15:12], 1);
	endproperty
	a_tc_route: assert property (p_tc_route) else $error("tc trim not routed");

	property p_freq_route;
		@(posedge CLK) disable iff (SYS_RST)
		##2 (REF_FREQ_TRIM == $past(trim_q[9:0], 1)) && (FREQ_COARSE == $past(trim_q[COARSE_MSB:COARSE_LSB], 1))
			&& (FREQ_FINE == $past(trim_q[FINE_MSB:FINE_LSB], 1));
	endproperty
	a_freq_route: assert property (p_freq_route) else $error("freq trim not routed");

	property p_tc_off;
		@(posedge CLK) disable iff (SYS_RST)
		(s_q.tc_out[2:0] == 3'h0) |=> !TC_COMP_ENABLE;
	endproperty
	a_tc_off: assert property (p_tc_off) else $error("compensation not off");

	property p_tc_dir;
		@(posedge CLK) disable iff (SYS_RST)
		1'b1 |=> (TC_COMP_POSITIVE == $past(s_q.tc_out[3], 1)) && (TC_COMP_MAGNITUDE == $past(s_q.tc_out[2:0], 1));
	endproperty
	a_tc_dir: assert property (p_tc_dir) else $error("tc direction wrong");

	property p_rdata_idle;
		@(posedge CLK) disable iff (SYS_RST)
		!s_q.rd_pend |-> (HRDATA == 32'h00000000);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside data phase");

	property p_bus_okay;
		@(posedge CLK) disable iff (SYS_RST)
		HREADYOUT && !HRESP;
	endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("slave stalled or answered error");

	property p_rd_high;
		@(posedge CLK) disable iff (SYS_RST)
		(addr_phase && !HWRITE && HADDR == OFF_TRIM_HIGH) |=>
			(HRDATA[31:8] == 24'h000000) && (HRDATA[7:0] == $past(trim_q[15:8], 1)) && (HRDATA[3:2] == 2'b00);
	endproperty
	a_rd_high: assert property (p_rd_high) else $error("read of high trim wrong");

	property p_rd_low;
		@(posedge CLK) disable iff (SYS_RST)
		(addr_phase && !HWRITE && HADDR == OFF_TRIM_LOW) |=>
			(HRDATA[31:8] == 24'h000000) && (HRDATA[7:0] == $past(trim_q[7:0], 1));
	endproperty
	a_rd_low: assert property (p_rd_low) else $error("read of low trim wrong");

	property p_wr_high;
		@(posedge CLK) disable iff (SYS_RST)
		(s_q.wr_pend && s_q.addr == OFF_TRIM_HIGH && !s_q.guard && !s_q.load_pulse) |=>
			(trim_q[15:8] == ($past(HWDATA[7:0], 1) & TRIM_IMPL_MASK[15:8]));
	endproperty
	a_wr_high: assert property (p_wr_high) else $error("unlocked high trim write lost");

	property p_wr_low;
		@(posedge CLK) disable iff (SYS_RST)
		(s_q.wr_pend && s_q.addr == OFF_TRIM_LOW && !s_q.guard && !s_q.load_pulse) |=>
			(trim_q[7:0] == $past(HWDATA[7:0], 1));
	endproperty
	a_wr_low: assert property (p_wr_low) else $error("unlocked low trim write lost");

	property p_load_latch;
		@(posedge CLK) disable iff (SYS_RST)
		s_q.load_pulse |-> s_q.loaded;
	endproperty
	a_load_latch: assert property (p_load_latch) else $error("load without loaded mark");

	property p_load_stays;
		@(posedge CLK) disable iff (SYS_RST)
		s_q.loaded |=> s_q.loaded;
	endproperty
	a_load_stays: assert property (p_load_stays) else $error("loaded mark dropped");

	property p_load_start;
		@(posedge CLK) disable iff (SYS_RST)
		(fv_ok && !s_q.loaded) |=> (s_q.load_pulse && s_q.loaded);
	endproperty
	a_load_start: assert property (p_load_start) else $error("factory load not started");

	property p_lock_set;
		@(posedge CLK) disable iff (SYS_RST)
		lock_ok |=> s_q.lock_flag;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock flag not set");

	property p_qual_set;
		@(posedge CLK) disable iff (SYS_RST)
		qual_ok |=> s_q.qual_flag;
	endproperty
	a_qual_set: assert property (p_qual_set) else $error("qualified flag not set");

	property p_lock_keep;
		@(posedge CLK) disable iff (SYS_RST)
		(s_q.lock_flag && !(trim_wr && s_q.pll_sel)) |=> s_q.lock_flag;
	endproperty
	a_lock_keep: assert property (p_lock_keep) else $error("lock flag cleared without cause");

	property p_qual_keep;
		@(posedge CLK) disable iff (SYS_RST)
		(s_q.qual_flag && !(trim_wr && s_q.pll_sel)) |=> s_q.qual_flag;
	endproperty
	a_qual_keep: assert property (p_qual_keep) else $error("qualified flag cleared without cause");

	property p_guard_hold;
		@(posedge CLK) disable iff (SYS_RST)
		!(s_q.wr_pend && s_q.addr == OFF_GUARD) |=> $stable(s_q.guard);
	endproperty
	a_guard_hold: assert property (p_guard_hold) else $error("guard changed without a write");

	property p_tc_on;
		@(posedge CLK) disable iff (SYS_RST)
		(s_q.tc_out[2:0] != 3'h0) |=> TC_COMP_ENABLE;
	endproperty
	a_tc_on: assert property (p_tc_on) else $error("compensation not on");
endmodule

// file: bench/osc_trim_regs_tb.sv
// Purpose: self-checking bench for the oscillator trim register bank
// Assumes: zero-wait AHB-Lite slave, factory word presented from time zero
// Notes: read data are checked by a monitor against a queue of expectations
`timescale 1ns/1ps
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin num_errors++; \
	$display("ERROR %s expected %h seen %h", nm, e, s); end end
module osc_trim_regs_tb;
	import osc_trim_pkg::*;
	logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, factory_valid, pll_set, qual_set;
	logic [ADDR_W-1:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize, tc_mag;
	logic [31:0] hwdata, hrdata, re, v;
	logic [15:0] ft;
	logic [7:0] lo;
	logic [3:0] tc_trim, coarse;
	logic [9:0] freq_trim;
	logic [5:0] fine;
	logic tc_en, tc_pos, lock_flag, qual_flag, rd_dp;
	logic [31:0] exp_q[$];
	int num_errors = 0;
	int comparisons = 0;
	int seed;
	osc_trim_regs osc_trim_regs_i (.CLK(clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hreadyout), .HWDATA(hwdata),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .FACTORY_TRIM(ft),
		.FACTORY_VALID(factory_valid), .PLL_LOCK_SET(pll_set), .OSC_QUAL_SET(qual_set),
		.TEMP_COEFF_TRIM(tc_trim), .REF_FREQ_TRIM(freq_trim), .FREQ_COARSE(coarse), .FREQ_FINE(fine),
		.TC_COMP_ENABLE(tc_en), .TC_COMP_POSITIVE(tc_pos), .TC_COMP_MAGNITUDE(tc_mag),
		.PLL_LOCK_FLAG(lock_flag), .OSC_QUALIFIED_FLAG(qual_flag));
	always #20 clk = ~clk;
	task tally_and_finish;
		if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// entered just after a rising edge; leaves just after the data phase ends
	task bus(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= w ? {v[31:8], d[7:0]} : v;
		if (!w) exp_q.push_back(d);
		rd_dp <= !w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd_dp <= 1'b0;
	endtask
	// the idle cycle lets a following read see the new contents
	task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		v = $random(seed);
		bus(a, 1'b1, {24'h0, d});
		@(posedge clk);
	endtask
	task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		bus(a, 1'b0, e);
	endtask
	task pulse_status;
		pll_set <= 1'b1;
		qual_set <= 1'b1;
		repeat (6) @(posedge clk);
		pll_set <= 1'b0;
		qual_set <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task flags(input logic e);
		@(negedge clk);
		`CHK("lock_flag", e, lock_flag)
		`CHK("qual_flag", e, qual_flag)
		@(posedge clk);
	endtask
	// read data are taken at the edge that ends the data phase
	always @(posedge clk) begin
		if (rd_dp) begin
			re = exp_q.pop_front();
			`CHK("hrdata", re, hrdata)
			`CHK("hresp", 1'b0, hresp)
		end
	end
	initial begin
		#200000;
		num_errors++;
		tally_and_finish();
	end
	initial begin
		seed = 32'h72b7;
		ft = 16'($random(seed));
		v = 32'h0;
		clk = 1'b0;
		sys_rst = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata, pll_set, qual_set, rd_dp} = '0;
		hsize = HSIZE_WORD;
		factory_valid = 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 20 && freq_trim !== ft[9:0]; i++) @(posedge clk);
		@(negedge clk);
		`CHK("tc_trim", ft[15:12], tc_trim)
		`CHK("freq_trim", ft[9:0], freq_trim)
		`CHK("coarse", ft[9:6], coarse)
		`CHK("fine", ft[5:0], fine)
		@(posedge clk);
		rd(OFF_TRIM_HIGH, {24'h0, ft[15:12], 2'b00, ft[9:8]});
		rd(OFF_TRIM_LOW, {24'h0, ft[7:0]});
		rd(8'h14, 32'h0);
		// a non-key value locks, so the trim write must bounce
		wr(OFF_GUARD, 8'h27);
		rd(OFF_GUARD, 32'h1);
		wr(OFF_TRIM_LOW, ~ft[7:0]);
		rd(OFF_TRIM_LOW, {24'h0, ft[7:0]});
		wr(OFF_GUARD, GUARD_UNLOCK_KEY);
		rd(OFF_GUARD, 32'h0);
		for (int c = 0; c < 16; c++) begin
			wr(OFF_TRIM_HIGH, {c[3:0], 4'hf});
			repeat (2) @(posedge clk);
			@(negedge clk);
			`CHK("tc_enable", c[2:0] != 3'b000, tc_en)
			`CHK("tc_positive", c[3], tc_pos)
			`CHK("tc_magnitude", c[2:0], tc_mag)
			`CHK("tc_trim", c[3:0], tc_trim)
			@(posedge clk);
			rd(OFF_TRIM_HIGH, {24'h0, c[3:0], 4'h3});
		end
		lo = 8'($random(seed));
		wr(OFF_TRIM_LOW, lo);
		repeat (2) @(posedge clk);
		@(negedge clk);
		`CHK("freq_trim", {2'b11, lo}, freq_trim)
		`CHK("coarse", {2'b11, lo[7:6]}, coarse)
		`CHK("fine", lo[5:0], fine)
		@(posedge clk);
		// accepted write with the pll not selected leaves the flags alone
		pulse_status();
		wr(OFF_TRIM_LOW, 8'h5a);
		flags(1'b1);
		wr(OFF_CLKSEL, 8'h01);
		rd(OFF_CLKSEL, 32'h1);
		rd(OFF_STATUS, 32'h7);
		wr(OFF_GUARD, 8'h00);
		wr(OFF_TRIM_LOW, 8'h3c);
		flags(1'b1);
		wr(OFF_GUARD, GUARD_UNLOCK_KEY);
		wr(OFF_TRIM_HIGH, 8'h91);
		flags(1'b0);
		pulse_status();
		wr(OFF_TRIM_LOW, 8'ha5);
		flags(1'b0);
		rd(OFF_STATUS, 32'h4);
		// lock first, so the second reset has something to undo
		wr(OFF_GUARD, 8'h00);
		sys_rst <= 1'b1;
		factory_valid <= 1'b0;
		ft <= 16'($random(seed));
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		factory_valid <= 1'b1;
		repeat (10) @(posedge clk);
		rd(OFF_TRIM_HIGH, {24'h0, ft[15:12], 2'b00, ft[9:8]});
		rd(OFF_TRIM_LOW, {24'h0, ft[7:0]});
		rd(OFF_GUARD, 32'h0);
		rd(OFF_CLKSEL, 32'h0);
		rd(OFF_STATUS, 32'h4);
		tally_and_finish();
	end
endmodule
